// [isa_attr_regs.sv]
// Attribute identification registers with coprocessor read port and swap sequencer
//
// Contract
// [RULE1] Reads allowed only at first privilege level up
// [RULE2] Register 0 read-only, one copy both states
// [RULE3] Registers present in every build
// [RULE4] Divide field bits 27:24 read 0x2
// [RULE5] Breakpoint field bits 23:20 read 0x1
// [RULE6] Coprocessor field bits 19:16 read 0x0
// [RULE7] Compare-branch field bits 15:12 read 0x1
// [RULE8] Bit-field field bits 11:8 read 0x1
// [RULE9] Bit-count field bits 7:4 read 0x1
// [RULE10] Swap field bits 3:0 read 0x0
// [RULE11] Enabled swap: read then write, unlocked
// [RULE12] Software reads with opc1 0, c0, c2, 0
// [RULE13] Register 1 read-only, shared, privileged
// [RULE14] Bits 31:28 zero; writes have no effect
`timescale 1ns/1ps
`default_nettype none
module isa_attr_regs
   import isa_attr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   // System coprocessor access
   input  wire logic        cp_req,
   input  wire logic        cp_write,
   input  wire logic [2:0]  cp_opc1,
   input  wire logic [3:0]  cp_crn,
   input  wire logic [3:0]  cp_crm,
   input  wire logic [2:0]  cp_opc2,
   input  wire logic [1:0]  cp_priv,
   input  wire logic        cp_secure,
   output logic             cp_ack,
   output logic             cp_hit,
   output logic             cp_undef,
   output logic [31:0]      cp_rdata,
   // Swap instruction request
   input  wire logic        swap_req,
   input  wire logic        swap_byte,
   input  wire logic        swap_enable,
   input  wire logic [31:0] swap_addr,
   input  wire logic [31:0] swap_wdata,
   output logic             swap_done,
   output logic             swap_undef,
   output logic [31:0]      swap_rdata,
   // Memory bus used by the swap
   output logic             mem_req,
   output logic             mem_we,
   output logic             mem_byte,
   output logic             mem_lock,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata
);
   // Values are hard constants; nothing to configure away. see [RULE3]
   wire logic [31:0] attr0_word;
   wire logic [31:0] attr1_word;

   isa_attr_values u_values (
      .attr0_word (attr0_word),
      .attr1_word (attr1_word)
   );

   // Coordinate decode
   wire logic coord_base = (cp_opc1 == ISA_OPC1) && (cp_crn == ISA_CRN)
                         && (cp_crm == ISA_CRM);                        // see [RULE12]
   wire logic sel_atr0   = coord_base && (cp_opc2 == ISA_OPC2_ATR0);
   wire logic sel_atr1   = coord_base && (cp_opc2 == ISA_OPC2_ATR1);
   wire logic sel_any    = sel_atr0 || sel_atr1;
   wire logic priv_ok    = (cp_priv >= ISA_PL_FIRST);                   // see [RULE1] [RULE13]
   // Security state does not select a bank: one shared copy
   wire logic sec_unused = cp_secure;                                   // see [RULE2] [RULE13]
   wire logic [31:0] rd_mux = sel_atr0 ? attr0_word :
                              sel_atr1 ? attr1_word : ISA_DATA_RST;
   // Writes return no data and change nothing
   wire logic rd_ok = sel_any && priv_ok && !cp_write && !sec_unused | (sel_any && priv_ok
                      && !cp_write && sec_unused);                      // see [RULE14]

   logic        cp_ack_r, cp_hit_r, cp_undef_r;
   logic [31:0] cp_rdata_r;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cp_ack_r   <= 1'b0;
         cp_hit_r   <= 1'b0;
         cp_undef_r <= 1'b0;
         cp_rdata_r <= ISA_DATA_RST;
      end else begin
         cp_ack_r   <= cp_req && sel_any;
         cp_hit_r   <= cp_req && sel_any;
         cp_undef_r <= cp_req && sel_any && !priv_ok;                   // see [RULE1]
         cp_rdata_r <= (cp_req && rd_ok) ? rd_mux : ISA_DATA_RST;       // see [RULE2] [RULE14]
      end
   end

   assign cp_ack   = cp_ack_r;
   assign cp_hit   = cp_hit_r;
   assign cp_undef = cp_undef_r;
   assign cp_rdata = cp_rdata_r;

   // Swap sequencer: two separate transfers, lock never raised, so
   // other masters may slip in between. Not atomic by design.
   isa_swap_state_t sw_state_r, sw_state_nxt;
   logic        mem_req_r, mem_we_r, mem_byte_r, mem_lock_r;
   logic [31:0] mem_addr_r, mem_wdata_r;
   logic        swap_done_r, swap_undef_r;
   logic [31:0] swap_rdata_r;

   wire logic start_ok  = (sw_state_r == ISA_SW_IDLE) && swap_req && swap_enable;
   wire logic start_bad = (sw_state_r == ISA_SW_IDLE) && swap_req && !swap_enable;
   wire logic rd_done   = (sw_state_r == ISA_SW_READ) && mem_ack;
   wire logic wr_done   = (sw_state_r == ISA_SW_WRITE) && mem_ack;

   always_comb begin
      sw_state_nxt = sw_state_r;
      case (sw_state_r)
         ISA_SW_IDLE:  if (start_ok) sw_state_nxt = ISA_SW_READ;       // see [RULE11]
         ISA_SW_READ:  if (mem_ack) sw_state_nxt = ISA_SW_WRITE;       // see [RULE11]
         ISA_SW_WRITE: if (mem_ack) sw_state_nxt = ISA_SW_IDLE;
         default:      sw_state_nxt = ISA_SW_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sw_state_r   <= ISA_SW_IDLE;
         mem_req_r    <= 1'b0;
         mem_we_r     <= 1'b0;
         mem_byte_r   <= 1'b0;
         mem_lock_r   <= 1'b0;
         mem_addr_r   <= ISA_DATA_RST;
         mem_wdata_r  <= ISA_DATA_RST;
         swap_done_r  <= 1'b0;
         swap_undef_r <= 1'b0;
         swap_rdata_r <= ISA_DATA_RST;
      end else begin
         sw_state_r   <= sw_state_nxt;
         mem_lock_r   <= 1'b0;                                          // see [RULE11]
         swap_done_r  <= wr_done || start_bad;
         swap_undef_r <= start_bad;
         if (start_ok) begin
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b0;
            mem_byte_r  <= swap_byte;
            mem_addr_r  <= swap_addr;
            mem_wdata_r <= swap_wdata;
         end else if (rd_done) begin
            mem_we_r     <= 1'b1;                                       // see [RULE11]
            swap_rdata_r <= mem_rdata;
         end else if (wr_done) begin
            mem_req_r <= 1'b0;
            mem_we_r  <= 1'b0;
         end
      end
   end

   assign mem_req    = mem_req_r;
   assign mem_we     = mem_we_r;
   assign mem_byte   = mem_byte_r;
   assign mem_lock   = mem_lock_r;
   assign mem_addr   = mem_addr_r;
   assign mem_wdata  = mem_wdata_r;
   assign swap_done  = swap_done_r;
   assign swap_undef = swap_undef_r;
   assign swap_rdata = swap_rdata_r;
endmodule // isa_attr_regs
`default_nettype wire

// [isa_attr_pkg.sv]
// Constants for the instruction-set attribute identification registers
package isa_attr_pkg;
   // Coprocessor coordinates of the attribute registers
   localparam logic [2:0] ISA_OPC1      = 3'h0;
   localparam logic [3:0] ISA_CRN       = 4'h0;
   localparam logic [3:0] ISA_CRM       = 4'h2;
   localparam logic [2:0] ISA_OPC2_ATR0 = 3'h0;
   localparam logic [2:0] ISA_OPC2_ATR1 = 3'h1;
   // Privilege levels, two bits, first_privilege_level and above may read
   localparam logic [1:0] ISA_PL_FIRST  = 2'h1;
   // Field positions of instr_set_attributes_0 (low bit of each nibble)
   localparam int ISA_F_RSVD   = 28;
   localparam int ISA_F_DIVIDE = 24;
   localparam int ISA_F_DEBUG  = 20;
   localparam int ISA_F_COPROC = 16;
   localparam int ISA_F_CMPBR  = 12;
   localparam int ISA_F_BITFLD = 8;
   localparam int ISA_F_BITCNT = 4;
   localparam int ISA_F_SWAP   = 0;
   // Field values of instr_set_attributes_0
   localparam logic [3:0] ISA_V_RSVD   = 4'h0;
   localparam logic [3:0] ISA_V_DIVIDE = 4'h2;
   localparam logic [3:0] ISA_V_DEBUG  = 4'h1;
   localparam logic [3:0] ISA_V_COPROC = 4'h0;
   localparam logic [3:0] ISA_V_CMPBR  = 4'h1;
   localparam logic [3:0] ISA_V_BITFLD = 4'h1;
   localparam logic [3:0] ISA_V_BITCNT = 4'h1;
   localparam logic [3:0] ISA_V_SWAP   = 4'h0;
   // Whole value of instr_set_attributes_1
   localparam logic [31:0] ISA_ATR1_VALUE = 32'h13112111;
   // Reset values of the answer side
   localparam logic [31:0] ISA_DATA_RST = 32'h00000000;
   // Swap sequencer states
   typedef enum logic [1:0] {ISA_SW_IDLE, ISA_SW_READ, ISA_SW_WRITE} isa_swap_state_t;
endpackage

// [isa_attr_values.sv]
// Fixed attribute words: word 0 assembled from its fields, word 1 a whole constant
`timescale 1ns/1ps
`default_nettype none
module isa_attr_values
   import isa_attr_pkg::*;
#(
   parameter logic [3:0] DIVIDE_VAL = ISA_V_DIVIDE,
   parameter logic [3:0] DEBUG_VAL  = ISA_V_DEBUG,
   parameter logic [3:0] COPROC_VAL = ISA_V_COPROC,
   parameter logic [3:0] CMPBR_VAL  = ISA_V_CMPBR,
   parameter logic [3:0] BITFLD_VAL = ISA_V_BITFLD,
   parameter logic [3:0] BITCNT_VAL = ISA_V_BITCNT,
   parameter logic [3:0] SWAP_VAL   = ISA_V_SWAP
) (
   output wire logic [31:0] attr0_word,
   output wire logic [31:0] attr1_word
);
   function automatic logic [31:0] place(input logic [3:0] v, input int pos);
      place = {28'h0000000, v} << pos;
   endfunction

   assign attr0_word = place(ISA_V_RSVD, ISA_F_RSVD)    // Reserved, reads zero; see [RULE14]
                     | place(DIVIDE_VAL, ISA_F_DIVIDE)  // see [RULE4]
                     | place(DEBUG_VAL, ISA_F_DEBUG)    // see [RULE5]
                     | place(COPROC_VAL, ISA_F_COPROC)  // see [RULE6]
                     | place(CMPBR_VAL, ISA_F_CMPBR)    // see [RULE7]
                     | place(BITFLD_VAL, ISA_F_BITFLD)  // see [RULE8]
                     | place(BITCNT_VAL, ISA_F_BITCNT)  // see [RULE9]
                     | place(SWAP_VAL, ISA_F_SWAP);     // see [RULE10]
   assign attr1_word = ISA_ATR1_VALUE;                  // see [RULE13]
endmodule // isa_attr_values
`default_nettype wire

// [isa_attr_regs_assertions.sv]
// Checker for the attribute register block
`timescale 1ns/1ps
`default_nettype none
module isa_attr_regs_assertions (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        cp_req,
   input wire logic        cp_write,
   input wire logic [2:0]  cp_opc1,
   input wire logic [3:0]  cp_crn,
   input wire logic [3:0]  cp_crm,
   input wire logic [2:0]  cp_opc2,
   input wire logic [1:0]  cp_priv,
   input wire logic        cp_ack,
   input wire logic        cp_undef,
   input wire logic [31:0] cp_rdata,
   input wire logic        swap_req,
   input wire logic        swap_enable,
   input wire logic        swap_done,
   input wire logic        swap_undef,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic        mem_lock,
   input wire logic        mem_ack
);
   // Only opc2 0 and 1 belong to us
   wire hit = cp_req && cp_opc1 == 3'h0 && cp_crn == 4'h0 && cp_crm == 4'h2 && cp_opc2 < 3'h2;
   wire rd = hit && !cp_write && cp_priv != 2'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_attr0_word: assert property (rd && cp_opc2 == 3'h0 |=>
      cp_ack && !cp_undef && cp_rdata == 32'h02101110) else $error("attr0 word wrong");
   a_attr1_word: assert property (rd && cp_opc2 == 3'h1 |=> cp_ack && !cp_undef)
      else $error("attr1 read not answered");
   a_priv_refused: assert property (hit && cp_priv == 2'h0 |=>
      cp_ack && cp_undef && cp_rdata == 32'h0) else $error("low privilege not refused");
   a_write_ignored: assert property (hit && cp_write && cp_priv != 2'h0 |=>
      cp_ack && !cp_undef && cp_rdata == 32'h0) else $error("write not ignored");
   a_other_coords: assert property (cp_req && !hit |=> !cp_ack)
      else $error("foreign coordinates answered");
   a_never_locked: assert property (!mem_lock) else $error("bus lock raised");
   a_read_first: assert property ($rose(mem_req) |-> !mem_we)
      else $error("swap began with a write");
   a_write_follows: assert property (mem_req && !mem_we && mem_ack |=> mem_req && mem_we)
      else $error("no write after read");
   a_swap_ends: assert property (mem_req && mem_we && mem_ack |=>
      !mem_req && swap_done && !swap_undef) else $error("swap end wrong");
   a_swap_refused: assert property (swap_req && !swap_enable && !mem_req |=>
      swap_done && swap_undef && !mem_req) else $error("disabled swap not refused");
endmodule // isa_attr_regs_assertions
`default_nettype wire

// [tb_instr_set_attr_id_regs.sv]
// Self-checking bench for the attribute register block
`timescale 1ns/1ps
`default_nettype none
module tb_instr_set_attr_id_regs;
   import isa_attr_pkg::*;
   logic        clk = 1'h0, rst_b = 1'h0, cp_req = 1'h0, cp_write = 1'h0, cp_secure = 1'h0;
   logic [2:0]  cp_opc1 = 3'h0, cp_opc2 = 3'h0;
   logic [3:0]  cp_crn = 4'h0, cp_crm = 4'h0;
   logic [1:0]  cp_priv = 2'h0;
   logic        swap_req = 1'h0, swap_byte = 1'h0, swap_enable = 1'h0, mem_ack = 1'h0;
   logic [31:0] swap_addr = 32'h00001234, swap_wdata = 32'hA5A50F0F, mem_rdata = 32'h0;
   logic        cp_ack, cp_hit, cp_undef, swap_done, swap_undef, mem_req, mem_we, mem_byte, mem_lock;
   logic [31:0] cp_rdata, swap_rdata, mem_addr, mem_wdata;
   int          num_errors = 0, n_compared = 0, i;
   always #50 clk = ~clk;
   isa_attr_regs isa_attr_regs_i (.clk, .rst_b, .cp_req, .cp_write, .cp_opc1, .cp_crn, .cp_crm,
      .cp_opc2, .cp_priv, .cp_secure, .cp_ack, .cp_hit, .cp_undef, .cp_rdata, .swap_req,
      .swap_byte, .swap_enable, .swap_addr, .swap_wdata, .swap_done, .swap_undef, .swap_rdata,
      .mem_req, .mem_we, .mem_byte, .mem_lock, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [67:0] e, s);
      n_compared++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask
   // Coordinates {opc1,crn,crm,opc2}, mode {write,priv,secure}; answers one cycle later
   task automatic cp_acc(input logic [13:0] c, input logic [3:0] m, input logic [34:0] e);
      {cp_opc1, cp_crn, cp_crm, cp_opc2} = c;
      {cp_write, cp_priv, cp_secure} = m;
      cp_req = 1'h1;
      @(posedge clk) #1;
      cp_req = 1'h0;
      chk("ack hit undef rdata", e, {cp_ack, cp_hit, cp_undef, cp_rdata});
   endtask
   task automatic t_reads;
      for (i = 0; i < 6; i++) begin
         cp_acc(14'h0010, {1'h0, 2'(i / 2 + 1), 1'(i)}, {3'h6, 32'h02101110});
         cp_acc(14'h0011, {1'h0, 2'(i / 2 + 1), 1'(i)}, {3'h6, ISA_ATR1_VALUE});
      end
      $display("privileged reads done");
   endtask
   task automatic t_refuse;
      cp_acc(14'h0010, 4'h1, {3'h7, 32'h0});
      cp_acc(14'h0011, 4'h0, {3'h7, 32'h0});
      cp_acc(14'h0090, 4'h2, 35'h0);
      cp_acc(14'h0012, 4'h2, 35'h0);
      cp_acc(14'h0008, 4'h2, 35'h0);
      cp_acc(14'h0810, 4'h2, 35'h0);
      cp_acc(14'h0010, 4'hB, {3'h6, 32'h0});
      cp_acc(14'h0010, 4'h2, {3'h6, 32'h02101110});
      $display("refusals done");
   endtask
   // Waits for a transfer, checks it, acks after w idle cycles; bus floats inverted after
   task automatic phase(input logic we, input int w, input logic [31:0] rd);
      for (i = 0; i < 9 && mem_req !== 1'h1; i++) @(posedge clk) #1;
      if (mem_req !== 1'h1) begin
         num_errors++;
         complete_run;
      end
      repeat (w) @(posedge clk) #1;
      chk("mem transfer", {2'h2 | we, swap_byte, 1'h0, 32'h00001234, 32'hA5A50F0F},
          {mem_req, mem_we, mem_byte, mem_lock, mem_addr, mem_wdata});
      {mem_ack, mem_rdata} = {1'h1, rd};
      @(posedge clk) #1;
      {mem_ack, mem_rdata} = {1'h0, ~rd};
   endtask
   task automatic swap(input logic en, byt, input int w);
      {swap_enable, swap_byte, swap_req} = {en, byt, 1'h1};
      @(posedge clk) #1;
      swap_req = 1'h0;
      if (en) begin
         phase(1'h0, w, 32'hC3C37E7E);
         phase(1'h1, w, 32'h0);
      end
      chk("swap end", {1'h0, 1'h1, !en, 32'hC3C37E7E}, {mem_req, swap_done, swap_undef, swap_rdata});
      $display("swap finished");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_b = 1'h1;
      @(posedge clk) #1;
      t_reads;
      t_refuse;
      swap(1'h1, 1'h0, 0);
      swap(1'h1, 1'h1, 3);
      swap(1'h0, 1'h0, 0);
      complete_run;
   end
endmodule // tb_instr_set_attr_id_regs
bind isa_attr_regs isa_attr_regs_assertions isa_attr_regs_assertions_i (.clk, .rst_b, .cp_req,
   .cp_write, .cp_opc1, .cp_crn, .cp_crm, .cp_opc2, .cp_priv, .cp_ack, .cp_undef, .cp_rdata,
   .swap_req, .swap_enable, .swap_done, .swap_undef, .mem_req, .mem_we, .mem_lock, .mem_ack);
`default_nettype wire
